/* rtl/tcg_clock_out.sv */
// Functional notes
// - Counter advances at half oscillator rate
// - Overflow reloads counter from reload pair
// - Output 50 percent duty, fosc/(4*(65536-reload))
// - No interrupt on overflow in clock-out mode
// - Square wave driven on clock output pin
// - Counting starts only when run set
// - Baud and clock-out share reload pair
//
// Third timer in clock-output mode with plain configuration ports.
// Assumes count writes come from a CPU in the ref_clk domain, one per cycle.
`timescale 1ns/1ps
`default_nettype none
module tcg_clock_out #(
	parameter int CNT_W = tcg_pkg::TCG_CNT_W
) (
	input  wire logic             ref_clk,
	input  wire logic             nrst,
	input  wire logic             clock_out_enable,
	input  wire logic             counter_timer_select,
	input  wire logic             run_control,
	input  wire logic             baud_enable,
	input  wire logic             ext_event,
	input  wire logic [7:0]       wr_data,
	input  wire logic             wr_count_low_byte,
	input  wire logic             wr_count_high_byte,
	input  wire logic             wr_reload_low_byte,
	input  wire logic             wr_reload_high_byte,
	output logic                  clock_out_pin_o,
	output logic                  clock_out_pin_oe,
	output logic                  overflow_irq,
	output logic                  baud_tick,
	output logic [CNT_W-1:0]      count_q,
	output logic [CNT_W-1:0]      reload_q
);
	logic tick;
	logic adv;
	logic ovf;
	logic clk_mode;

	// Byte-lane merge shared by the counter and the reload pair, so both follow one write rule
	function automatic logic [CNT_W-1:0] byte_merge(
		input logic [CNT_W-1:0] old_val,
		input logic [7:0]       data,
		input logic             wr_low,
		input logic             wr_high
	);
		logic [CNT_W-1:0] merged;
		merged = old_val;
		if (wr_low) begin
			merged[7:0] = data;
		end
		if (wr_high) begin
			merged[15:8] = data;
		end
		return merged;
	endfunction : byte_merge

	// Clock-out needs the internal timebase; external counting keeps the pin as input
	assign clk_mode = clock_out_enable & ~counter_timer_select;

	tcg_prescaler u_pre (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.run     (run_control),
		.tick    (tick)
	);

	assign adv = counter_timer_select ? (run_control & ext_event) : tick;
	assign ovf = adv & (count_q == tcg_pkg::TCG_CNT_MAX);

	// Byte writes win over counting in the same cycle, as a CPU would expect
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			count_q <= tcg_pkg::TCG_CNT_RST;
		end else if (wr_count_low_byte || wr_count_high_byte) begin
			count_q <= byte_merge(count_q, wr_data, wr_count_low_byte, wr_count_high_byte);
		end else if (ovf) begin
			count_q <= reload_q;
		end else if (adv) begin
			count_q <= count_q + 16'h0001;
		end
	end

	// One reload pair feeds both clock-out and baud generation
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			reload_q <= tcg_pkg::TCG_RELOAD_RST;
		end else begin
			reload_q <= byte_merge(reload_q, wr_data, wr_reload_low_byte, wr_reload_high_byte);
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			clock_out_pin_o  <= tcg_pkg::TCG_PIN_RST;
			clock_out_pin_oe <= 1'b0;
		end else begin
			clock_out_pin_oe <= clk_mode;
			if (!clk_mode) begin
				clock_out_pin_o <= tcg_pkg::TCG_PIN_RST;
			end else if (ovf) begin
				clock_out_pin_o <= ~clock_out_pin_o;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			overflow_irq <= 1'b0;
			baud_tick    <= 1'b0;
		end else begin
			overflow_irq <= ovf & ~clk_mode & ~baud_enable;
			baud_tick    <= ovf & baud_enable;
		end
	end

	// One quiet cycle: clock-out mode, running, no count write, no overflow due
	sequence s_quiet_cycle;
		clk_mode && run_control && !wr_count_low_byte && !wr_count_high_byte
			&& count_q != tcg_pkg::TCG_CNT_MAX;
	endsequence

	// Two quiet cycles hold exactly one prescaler tick whatever its phase
	property p_half_rate;
		@(posedge ref_clk) disable iff (!nrst)
		s_quiet_cycle ##1 s_quiet_cycle |=> (count_q - $past(count_q, 2)) == 16'h0001;
	endproperty
	a_half_rate: assert property (p_half_rate) else $error("count not at half rate");

	property p_reload;
		@(posedge ref_clk) disable iff (!nrst)
		(ovf && !wr_count_low_byte && !wr_count_high_byte) |=> count_q == $past(reload_q);
	endproperty
	a_reload: assert property (p_reload) else $error("overflow did not reload");

	property p_no_irq;
		@(posedge ref_clk) disable iff (!nrst)
		clk_mode |=> !overflow_irq;
	endproperty
	a_no_irq: assert property (p_no_irq) else $error("irq in clock-out mode");

	property p_toggle;
		@(posedge ref_clk) disable iff (!nrst)
		(clk_mode && ovf) |=> clock_out_pin_o != $past(clock_out_pin_o);
	endproperty
	a_toggle: assert property (p_toggle) else $error("pin missed toggle");

	property p_hold;
		@(posedge ref_clk) disable iff (!nrst)
		(clk_mode && !ovf) |=> clock_out_pin_o == $past(clock_out_pin_o);
	endproperty
	a_hold: assert property (p_hold) else $error("pin changed without overflow");

	property p_drive;
		@(posedge ref_clk) disable iff (!nrst)
		clk_mode |=> clock_out_pin_oe;
	endproperty
	a_drive: assert property (p_drive) else $error("pin not driven");

	property p_stopped;
		@(posedge ref_clk) disable iff (!nrst)
		(!run_control && !wr_count_low_byte && !wr_count_high_byte) |=> $stable(count_q);
	endproperty
	a_stopped: assert property (p_stopped) else $error("count moved while stopped");

	property p_shared;
		@(posedge ref_clk) disable iff (!nrst)
		(ovf && baud_enable) |=> baud_tick;
	endproperty
	a_shared: assert property (p_shared) else $error("baud tick missing");

	property p_baud_quiet;
		@(posedge ref_clk) disable iff (!nrst)
		!baud_enable |=> !baud_tick;
	endproperty
	a_baud_quiet: assert property (p_baud_quiet) else $error("baud tick while baud off");

	// Outside clock-out mode and with baud off, the overflow is an ordinary timer request
	property p_timer_irq;
		@(posedge ref_clk) disable iff (!nrst)
		(ovf && !clk_mode && !baud_enable) |=> overflow_irq;
	endproperty
	a_timer_irq: assert property (p_timer_irq) else $error("timer request missing");

	property p_oe_off;
		@(posedge ref_clk) disable iff (!nrst)
		!clk_mode |=> !clock_out_pin_oe;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("pin driven outside clock-out mode");

	// Released pin rests high so the load sees no stray edge on the next start
	property p_pin_idle;
		@(posedge ref_clk) disable iff (!nrst)
		!clk_mode |=> clock_out_pin_o == tcg_pkg::TCG_PIN_RST;
	endproperty
	a_pin_idle: assert property (p_pin_idle) else $error("pin not at idle level");

	// Event counting skips the prescaler
	property p_ext_count;
		@(posedge ref_clk) disable iff (!nrst)
		(counter_timer_select && run_control && ext_event && !wr_count_low_byte && !wr_count_high_byte
			&& count_q != tcg_pkg::TCG_CNT_MAX) |=> count_q == $past(count_q) + 16'h0001;
	endproperty
	a_ext_count: assert property (p_ext_count) else $error("event not counted");

	// A single-lane write touches only its own byte
	sequence s_count_low_write;
		wr_count_low_byte && !wr_count_high_byte;
	endsequence

	property p_count_low_write;
		@(posedge ref_clk) disable iff (!nrst)
		s_count_low_write |=> count_q[7:0] == $past(wr_data) && count_q[15:8] == $past(count_q[15:8]);
	endproperty
	a_count_low_write: assert property (p_count_low_write) else $error("count low byte write wrong");

	property p_reload_high_write;
		@(posedge ref_clk) disable iff (!nrst)
		(wr_reload_high_byte && !wr_reload_low_byte)
			|=> reload_q[15:8] == $past(wr_data) && reload_q[7:0] == $past(reload_q[7:0]);
	endproperty
	a_reload_high_write: assert property (p_reload_high_write) else $error("reload high byte write wrong");
endmodule : tcg_clock_out
`default_nettype wire

/* rtl/tcg_pkg.sv */
// Package for the timer clock-output generator: widths, reset values, prescale.
// Assumes a single oscillator clock domain.
`default_nettype none
package tcg_pkg;
	localparam int          TCG_CNT_W       = 16;
	localparam logic [15:0] TCG_CNT_RST     = 16'h0000;
	localparam logic [15:0] TCG_RELOAD_RST  = 16'h0000;
	localparam logic [15:0] TCG_CNT_MAX     = 16'hFFFF;
	localparam int          TCG_PRESCALE    = 2;
	localparam logic        TCG_PIN_RST     = 1'b1;
endpackage : tcg_pkg
`default_nettype wire

/* rtl/tcg_prescaler.sv */
// Divides the oscillator clock into a one-cycle tick every other edge.
// Assumes ref_clk is the oscillator and the tick is sampled on the same clock.
`timescale 1ns/1ps
`default_nettype none
module tcg_prescaler (
	input  wire logic ref_clk,
	input  wire logic nrst,
	input  wire logic run,
	output var  logic tick
);
	logic phase_q;

	// Phase restarts when stopped so the first tick is two edges after start
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			phase_q <= 1'b0;
		end else if (!run) begin
			phase_q <= 1'b0;
		end else begin
			phase_q <= ~phase_q;
		end
	end

	assign tick = run & phase_q;
endmodule : tcg_prescaler
`default_nettype wire

/* tb/tcg_pin_load.sv */
// Far-side load clocked by the generated pin.
// Assumes the pin only counts while its enable is high.
`timescale 1ns/1ps
`default_nettype none
module tcg_pin_load (
	input  wire logic        pin,
	input  wire logic        pin_oe,
	output var  logic [15:0] n_edges
);
	initial n_edges = 16'h0000;
	always @(posedge pin) if (pin_oe) n_edges <= n_edges + 16'h0001;
endmodule : tcg_pin_load
`default_nettype wire

/* tb/timer_clock_output_generator_bench.sv */
// Bench for the clock-output timer: loads, runs, times the pin.
// Assumes ref_clk at 25 MHz and the one-edge write contract.
`timescale 1ns/1ps
`default_nettype none
module timer_clock_output_generator_bench;
	logic ref_clk, nrst, cen, cts, run, baud, ev, wl, wh, rl, rh, po, poe, irq, bt, ex;
	logic [7:0] wd;
	logic [15:0] cnt, rld, edges, e0;
	int n_mismatch, n_compared, r, c, len, n_irq, n_bt;
	int exp_q[$];
	tcg_clock_out dut (.ref_clk(ref_clk), .nrst(nrst), .clock_out_enable(cen), .counter_timer_select(cts),
		.run_control(run), .baud_enable(baud), .ext_event(ev), .wr_data(wd), .wr_count_low_byte(wl),
		.wr_count_high_byte(wh), .wr_reload_low_byte(rl), .wr_reload_high_byte(rh), .clock_out_pin_o(po),
		.clock_out_pin_oe(poe), .overflow_irq(irq), .baud_tick(bt), .count_q(cnt), .reload_q(rld));
	tcg_pin_load load (.pin(po), .pin_oe(poe), .n_edges(edges));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic end_of_test;
		$display("%0d mismatches, %0d compared", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : end_of_test
	task automatic load16(input logic sel, input logic [15:0] v);
		@(posedge ref_clk);
		wd <= v[7:0];
		{rl, wl} <= {sel, !sel};
		@(posedge ref_clk);
		wd <= v[15:8];
		{rl, wl, rh, wh} <= {2'b00, sel, !sel};
		@(posedge ref_clk);
		{rh, wh} <= 2'b00;
		#1;
	endtask : load16
	// Cycles until the pin changes; pulses are tallied on the way
	task automatic half(output int n);
		logic p;
		p = po;
		n = 0;
		do begin
			@(posedge ref_clk);
			#1;
			n++;
			n_irq += irq;
			n_bt += bt;
		end while (po === p && n < 2000);
	endtask : half
	initial begin
		ref_clk = 0;
		forever #20 ref_clk = ~ref_clk;
	end
	initial begin
		#2000000;
		n_mismatch++;
		end_of_test();
	end
	initial begin
		{nrst, cen, cts, run, baud, ev, wl, wh, rl, rh, wd} = '0;
		{n_mismatch, n_compared} = '0;
		void'($urandom(41181));
		repeat (2) @(posedge ref_clk);
		nrst <= 1;
		#1;
		chk(po, 1'b1);
		for (int i = 0; i < 4; i++) begin
			r = (i == 0) ? 32'hFFFF : 32'hFF00 + $urandom % 241;
			c = 32'hFF00 + $urandom % 256;
			load16(1, r[15:0]);
			chk(rld, r);
			load16(0, c[15:0]);
			repeat (3) @(posedge ref_clk);
			chk(cnt, c);
			cen <= 1;
			baud <= i[0];
			@(posedge ref_clk);
			run <= 1;
			half(len);
			{n_irq, n_bt} = '0;
			e0 = edges;
			repeat (4) exp_q.push_back(tcg_pkg::TCG_PRESCALE * (65536 - r));
			repeat (4) begin
				half(len);
				chk(len, exp_q.pop_front());
			end
			chk(poe, 1'b1);
			chk(edges - e0, 2);
			chk(n_irq, 0);
			chk(n_bt, 4 * i[0]);
			@(posedge ref_clk);
			{cen, run, baud} <= 3'b000;
		end
		// Timer mode: the model counts every other edge and expects a request per overflow
		r = 32'hFFF0 + $urandom % 16;
		c = 32'hFFF8 + $urandom % 8;
		load16(1, r[15:0]);
		load16(0, c[15:0]);
		@(posedge ref_clk);
		run <= 1;
		for (int k = 1; k <= 120; k++) begin
			@(posedge ref_clk);
			#1;
			ex = (k % 2 == 0) && (c == 32'hFFFF);
			if (k % 2 == 0) c = ex ? r : c + 1;
			chk(cnt, c);
			chk(irq, ex);
			chk(bt, 1'b0);
		end
		@(posedge ref_clk);
		run <= 0;
		// Event counting: each pulse counts at full rate, the pin stays released
		c = 32'h1000 + $urandom % 256;
		load16(0, c[15:0]);
		chk(poe, 1'b0);
		@(posedge ref_clk);
		{cts, cen} <= 2'b11;
		@(posedge ref_clk);
		run <= 1;
		for (int k = 0; k < 60; k++) begin
			@(posedge ref_clk);
			ev <= !ev && ($urandom % 2);
			#1;
			chk(cnt, c);
			c += ev;
		end
		@(posedge ref_clk);
		{ev, run, cts, cen} <= 4'b0000;
		#1;
		chk(cnt, c);
		chk(poe, 1'b0);
		end_of_test();
	end
endmodule : timer_clock_output_generator_bench
`default_nettype wire
